// ### host_drv_model.sv
// host_drv_model: driver-side word accesses to the list-pointer bank
// assumes the bank's clock; strobes change only at falling edges
`timescale 1ns/1ps
`default_nettype none
module host_drv_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_offset_o,
    output logic [31:0] reg_wdata_o,
    input wire logic [31:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_offset_o = 8'h00;
        reg_wdata_o = 32'h0000_0000;
    end
    // callers keep reserved low bits zero except the alignment probe
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        @(negedge clk_i);
        reg_wr_o = 1'b1;
        reg_offset_o = off;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        // released data is not left looking valid
        reg_wdata_o = ~d;
    endtask
    // no answer in the cycle after the strobe reads back as unknown
    task automatic rd(input logic [7:0] off, output logic [31:0] d);
        @(negedge clk_i);
        reg_rd_o = 1'b1;
        reg_offset_o = off;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        d = reg_rvalid_i ? reg_rdata_i : 32'hxxxx_xxxx;
    endtask
endmodule // host_drv_model
`default_nettype wire

// ### list_ptr_pkg.sv
// list_ptr_pkg: offsets, field layouts and reset values of the list-pointer registers
// assumes a 32-bit register access port decoded by byte offset within the memory window
package list_ptr_pkg;
    localparam logic [7:0] COMM_AREA_BASE_OFF = 8'h18;
    localparam logic [7:0] PERIODIC_CUR_OFF = 8'h1c;
    localparam logic [7:0] CONTROL_HEAD_OFF = 8'h20;
    localparam int COMM_AREA_LSB = 8;
    localparam int DESC_PTR_LSB = 4;
    localparam logic [31:0] COMM_AREA_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIODIC_CUR_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_HEAD_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// ### ohci_list_pointer_regs.sv
// ohci_list_pointer_regs: communication-area base, periodic-current and control-head pointers
// assumes register port already decoded to this function's memory window; one cycle read latency
`timescale 1ns/1ps
`default_nettype none
module ohci_list_pointer_regs
    import list_ptr_pkg::*;
#(
    parameter int PTR_WIDTH = 28
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register access within the memory window
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_offset_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // controller side
    input wire logic periodic_done_i,
    input wire logic [31:0] periodic_next_i,
    input wire logic init_load_i,
    input wire logic [31:0] shared_head_i,
    output logic [31:0] comm_area_base_o
);
    // the pointer fields are fixed at 31..4; any other width would misplace the read word
    if (PTR_WIDTH != 32 - DESC_PTR_LSB) begin : gen_width_check
        $error("PTR_WIDTH must match the 31..4 pointer field");
    end

    typedef struct packed {
        logic [31-COMM_AREA_LSB:0] comm_area;
        logic [31:0] rdata;
        logic rvalid;
    } state_s;

    state_s st;
    state_s next_st;
    logic [PTR_WIDTH-1:0] periodic_current_field;
    logic [PTR_WIDTH-1:0] control_head_field;
    logic [31:0] periodic_word;
    logic [31:0] control_word;
    logic hit_base;
    logic hit_periodic;
    logic hit_control;
    logic hit_mapped;
    logic base_wr;
    logic ro_wr;

    // one decode serves the write path and the checks; the read mux compares the offset itself
    assign hit_base = reg_offset_i == COMM_AREA_BASE_OFF;
    assign hit_periodic = reg_offset_i == PERIODIC_CUR_OFF;
    assign hit_control = reg_offset_i == CONTROL_HEAD_OFF;
    assign hit_mapped = hit_base || hit_periodic || hit_control;
    assign base_wr = reg_wr_i && hit_base;
    // writes to the pointers go nowhere; named only so the checks can see them
    assign ro_wr = reg_wr_i && (hit_periodic || hit_control);

    ptr_update_if #(.WIDTH(PTR_WIDTH)) periodic_upd ();
    ptr_update_if #(.WIDTH(PTR_WIDTH)) control_upd ();

    // only the controller can move these; bus writes never reach them
    assign periodic_upd.load = periodic_done_i;
    assign periodic_upd.value = periodic_next_i[31:DESC_PTR_LSB];
    assign control_upd.load = init_load_i;
    assign control_upd.value = shared_head_i[31:DESC_PTR_LSB];

    ptr_field_reg #(.WIDTH(PTR_WIDTH)) periodic_reg (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .upd(periodic_upd),
        .field_o(periodic_current_field)
    );

    ptr_field_reg #(.WIDTH(PTR_WIDTH)) control_reg (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .upd(control_upd),
        .field_o(control_head_field)
    );

    assign periodic_word = {periodic_current_field, 4'h0};
    assign control_word = {control_head_field, 4'h0};

    always_comb begin
        next_st = st;
        next_st.rvalid = reg_rd_i;
        // low bits are not stored at all, so all-ones readback reveals the alignment
        if (base_wr) begin
            next_st.comm_area = reg_wdata_i[31:COMM_AREA_LSB];
        end
        if (reg_rd_i) begin
            unique case (reg_offset_i)
                COMM_AREA_BASE_OFF: next_st.rdata = {st.comm_area, 8'h00};
                PERIODIC_CUR_OFF: next_st.rdata = periodic_word;
                CONTROL_HEAD_OFF: next_st.rdata = control_word;
                default: next_st.rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st.comm_area <= COMM_AREA_RESET[31:COMM_AREA_LSB];
            st.rdata <= 32'h0000_0000;
            st.rvalid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // controller fetches shared structures from this base; low byte is never stored
    assign comm_area_base_o = {st.comm_area, 8'h00};

    assign reg_rdata_o = st.rdata;
    assign reg_rvalid_o = st.rvalid;

    // every answer and every pointer move is due exactly one edge after its strobe
    base_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        base_wr
        |=> comm_area_base_o == {$past(reg_wdata_i[31:COMM_AREA_LSB]), 8'h00})
        else $error("base write not stored");

    base_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !base_wr
        |=> $stable(comm_area_base_o))
        else $error("base changed without a write");

    low_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i && hit_base
        |=> reg_rdata_o[7:0] == 8'h00)
        else $error("base low bits read nonzero");

    align_probe_a: assert property (@(posedge clk_i) disable iff (srst_i)
        base_wr && reg_wdata_i == 32'hffff_ffff
        |=> comm_area_base_o == 32'hffff_ff00)
        else $error("alignment probe wrong");

    base_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i && hit_base
        |=> reg_rvalid_o && reg_rdata_o == $past(comm_area_base_o))
        else $error("base read wrong");

    periodic_upd_a: assert property (@(posedge clk_i) disable iff (srst_i)
        periodic_done_i
        |=> periodic_word == {$past(periodic_next_i[31:DESC_PTR_LSB]), 4'h0})
        else $error("periodic pointer not updated");

    periodic_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !periodic_done_i
        |=> $stable(periodic_word))
        else $error("periodic pointer moved without a load");

    periodic_live_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i && hit_periodic
        |=> reg_rvalid_o && reg_rdata_o == $past(periodic_word))
        else $error("periodic read not live");

    periodic_ro_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ro_wr && !periodic_done_i
        |=> $stable(periodic_word))
        else $error("periodic pointer written by bus");

    control_init_a: assert property (@(posedge clk_i) disable iff (srst_i)
        init_load_i
        |=> control_word == {$past(shared_head_i[31:DESC_PTR_LSB]), 4'h0})
        else $error("control head not loaded");

    control_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !init_load_i
        |=> $stable(control_word))
        else $error("control head moved without a load");

    control_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i && hit_control
        |=> reg_rvalid_o && reg_rdata_o == $past(control_word))
        else $error("control head read wrong");

    ro_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ro_wr && !init_load_i
        |=> $stable(control_word))
        else $error("control head written by bus");

    read_answer_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i
        |=> reg_rvalid_o)
        else $error("read not answered");

    answer_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !reg_rd_i
        |=> !reg_rvalid_o)
        else $error("read answer without a read");

    read_stands_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !reg_rd_i
        |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    unmapped_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
        reg_rd_i && !hit_mapped
        |=> reg_rvalid_o && reg_rdata_o == UNMAPPED_READ)
        else $error("unmapped read not zero");

    reset_values_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> comm_area_base_o == COMM_AREA_RESET && periodic_word == PERIODIC_CUR_RESET
            && control_word == CONTROL_HEAD_RESET && !reg_rvalid_o && reg_rdata_o == 32'h0000_0000)
        else $error("registers not at reset values");
endmodule // ohci_list_pointer_regs
`default_nettype wire

// ### ptr_field_reg.sv
// ptr_field_reg: one pointer field, loaded only by the controller, never by a register write
// assumes srst_i synchronous active high, clk_i the core clock
`timescale 1ns/1ps
`default_nettype none
module ptr_field_reg #(
    parameter int WIDTH = 28
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // update from controller
    ptr_update_if.dst upd,
    // stored field
    output logic [WIDTH-1:0] field_o
);
    typedef struct packed {
        logic [WIDTH-1:0] field;
    } state_s;

    // a zero-width field has nothing to hold
    if (WIDTH < 1) begin : gen_width_check
        $error("WIDTH must be at least one");
    end

    state_s st;
    state_s next_st;

    always_comb begin
        next_st = st;
        if (upd.load) begin
            next_st.field = upd.value;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign field_o = st.field;

    hold_no_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !upd.load |=> $stable(field_o)) else $error("pointer changed without a load");
    load_takes_a: assert property (@(posedge clk_i) disable iff (srst_i)
        upd.load |=> field_o == $past(upd.value)) else $error("pointer load not taken");
endmodule // ptr_field_reg
`default_nettype wire

// ### ptr_update_if.sv
// ptr_update_if: load strobe and value carried from the top into a pointer register
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface ptr_update_if #(parameter int WIDTH = 28);
    logic load;
    logic [WIDTH-1:0] value;
    modport src (output load, output value);
    modport dst (input load, input value);
endinterface : ptr_update_if
`default_nettype wire

// ### tb.sv
// tb: self-checking bench for the list-pointer register bank
// assumes host_drv_model as the driver; controller strobes made here
`timescale 1ns/1ps
`default_nettype none
module tb;
    import list_ptr_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr, rd, rv, pdone = 1'b0, iload = 1'b0;
    logic [7:0] off;
    logic [31:0] wd, rdat, base, pnext = 32'h0, shead = 32'h0;
    int n_fail = 0;
    int checked = 0;
    always #25 clk_i = ~clk_i;
    host_drv_model drv (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_offset_o(off),
        .reg_wdata_o(wd), .reg_rdata_i(rdat), .reg_rvalid_i(rv));
    ohci_list_pointer_regs dut (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_offset_i(off), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
        .periodic_done_i(pdone), .periodic_next_i(pnext), .init_load_i(iload),
        .shared_head_i(shead), .comm_area_base_o(base));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle controller strobe carrying a pointer value
    task automatic ctl(input bit init, input logic [31:0] v);
        @(negedge clk_i);
        iload = init;
        pdone = !init;
        shead = v;
        pnext = v;
        @(negedge clk_i);
        iload = 1'b0;
        pdone = 1'b0;
        shead = ~v;
        pnext = ~v;
    endtask
    task automatic t_reset();
        logic [31:0] d;
        drv.rd(COMM_AREA_BASE_OFF, d);
        chk("base after reset", d, 32'h0000_0000);
        drv.rd(PERIODIC_CUR_OFF, d);
        chk("periodic after reset", d, 32'h0000_0000);
        drv.rd(CONTROL_HEAD_OFF, d);
        chk("head after reset", d, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_base();
        logic [31:0] d;
        drv.wr(COMM_AREA_BASE_OFF, 32'hffff_ffff);
        drv.rd(COMM_AREA_BASE_OFF, d);
        chk("base all ones", d, 32'hffff_ff00);
        chk("base output", base, 32'hffff_ff00);
        drv.wr(COMM_AREA_BASE_OFF, 32'h1234_5600);
        drv.rd(COMM_AREA_BASE_OFF, d);
        chk("base pattern", d, 32'h1234_5600);
        $display("test base done");
    endtask
    task automatic t_periodic();
        logic [31:0] d;
        ctl(1'b0, 32'h1234_5678);
        drv.rd(PERIODIC_CUR_OFF, d);
        chk("periodic first", d, 32'h1234_5670);
        ctl(1'b0, 32'haaaa_555f);
        drv.wr(PERIODIC_CUR_OFF, 32'h0f0f_0f00);
        drv.rd(PERIODIC_CUR_OFF, d);
        chk("periodic second", d, 32'haaaa_5550);
        $display("test periodic done");
    endtask
    task automatic t_head();
        logic [31:0] d;
        ctl(1'b1, 32'habcd_ef0f);
        drv.wr(CONTROL_HEAD_OFF, 32'h5555_5550);
        drv.rd(CONTROL_HEAD_OFF, d);
        chk("head loaded", d, 32'habcd_ef00);
        drv.rd(PERIODIC_CUR_OFF, d);
        chk("periodic kept", d, 32'haaaa_5550);
        drv.rd(8'h24, d);
        chk("unmapped read", d, UNMAPPED_READ);
        $display("test head done");
    endtask
    // reset in mid-run must clear every register and the base output
    task automatic t_midreset();
        logic [31:0] d;
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        chk("base output after reset", base, COMM_AREA_RESET);
        drv.rd(COMM_AREA_BASE_OFF, d);
        chk("base cleared", d, COMM_AREA_RESET);
        @(negedge clk_i);
        chk("valid one cycle", 32'(rv), 32'h0000_0000);
        drv.rd(PERIODIC_CUR_OFF, d);
        chk("periodic cleared", d, PERIODIC_CUR_RESET);
        drv.rd(CONTROL_HEAD_OFF, d);
        chk("head cleared", d, CONTROL_HEAD_RESET);
        $display("test mid-run reset done");
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;
        t_reset();
        t_base();
        t_periodic();
        t_head();
        t_midreset();
        final_report();
    end
    // tests need about 60 cycles; 400 cycles means a hang
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule // tb
`default_nettype wire
